// >>> trigger_playback_clock_control.sv
// replay fifo and trigger sequencer with sample clock range selection
`timescale 1ns/1ps
`default_nettype none
`include "trig_map.svh"

// ==================================================
// shift fifo: head word is always a register
module replay_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               count;
    logic                        notFull;
    logic                        notEmpty;
  } fifo_t;
  fifo_t q;
  fifo_t d;
  logic  push;
  logic  pop;
  logic [CW-1:0] slot;

  // refuse shapes the shift logic cannot serve
  if (DEPTH < 2 || WIDTH < 1) begin : g_badShape
    $error("replay_fifo: depth below 2 or width below 1");
  end

  // pop shifts toward the head, push lands behind the last held word
  always_comb begin
    d = q;
    push = inValid && q.notFull;
    pop = outReady && q.notEmpty;
    slot = q.count - CW'(pop);
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        d.mem[i] = q.mem[i + 1];
      end
    end
    if (push) begin
      d.mem[slot] = inData;
    end
    d.count = q.count + CW'(push) - CW'(pop);
    d.notFull = (d.count != CW'(DEPTH));
    d.notEmpty = (d.count != '0);
    if (rst) begin
      d = '0;
      d.notFull = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign inReady  = q.notFull;
  assign outData  = q.mem[0];
  assign outValid = q.notEmpty;
endmodule : replay_fifo

// ==================================================
// top: register slave, trigger qualification, replay sequencer, rate selection
module trigger_playback_clock_control #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               trigComp,
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire trig_pkg::edit_req_t editReq,
  output trig_pkg::sample_t       sampleOut,
  output logic                    sampleValid,
  input  wire logic               sampleReady,
  output logic [2:0]              filterSel,
  output logic [31:0]             sampleRate,
  output logic                    playing
);
  import trig_pkg::*;

  // refuse a fifo too shallow for the shift logic
  if (FIFO_DEPTH < 2) begin : g_badDepth
    $error("trigger_playback_clock_control: fifo depth below 2");
  end

  state_t  q;
  state_t  n;
  logic    fifoReady;
  sample_t pushWord;
  logic    push;
  logic    lvl;
  logic    trigEvt;
  logic    gateOn;
  logic    lastSample;
  logic    triggered;

  // ==================================================
  // rate helpers
  function automatic logic [31:0] decHigh(input logic [2:0] dec);
    case (dec)
      3'h0:    decHigh = `TRIG_DEC0_HI;
      3'h1:    decHigh = `TRIG_DEC1_HI;
      3'h2:    decHigh = `TRIG_DEC2_HI;
      3'h3:    decHigh = `TRIG_DEC3_HI;
      default: decHigh = `TRIG_DEC4_HI;
    endcase
  endfunction : decHigh

  function automatic logic [31:0] decLow(input logic [2:0] dec);
    case (dec)
      3'h0:    decLow = `TRIG_DEC0_LO;
      3'h1:    decLow = `TRIG_DEC1_LO;
      3'h2:    decLow = `TRIG_DEC2_LO;
      3'h3:    decLow = `TRIG_DEC3_LO;
      default: decLow = `TRIG_DEC4_LO;
    endcase
  endfunction : decLow

  // confine a requested rate to the decade or to the free range
  function automatic logic [31:0] clampRate(input logic [31:0] r, input logic lim,
                                            input logic [2:0] dec);
    logic [31:0] lo;
    logic [31:0] hi;
    lo = lim ? decLow(dec) : `TRIG_FREE_LO;
    hi = lim ? decHigh(dec) : `TRIG_FREE_HI;
    if (r < lo) clampRate = lo;
    else if (r > hi) clampRate = hi;
    else clampRate = r;
  endfunction : clampRate

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) merge[b*8 +: 8] = wd[b*8 +: 8];
    end
  endfunction : merge

  // ==================================================
  // trigger qualification on the selected level: synchronised comparator or internal bit
  assign lvl       = q.srcExt ? q.sync2 : q.intLevel;
  assign trigEvt   = q.slopeNeg ? (q.lvlPrev && !lvl)
                                : (!q.lvlPrev && lvl);
  assign gateOn    = q.slopeNeg ? !lvl : lvl;
  assign lastSample = (q.addr == q.points - 16'h0001);
  assign push      = (q.seq == SEQ_PLAY) && fifoReady;
  assign pushWord  = '{last: lastSample, addr: q.addr};
  assign triggered = (q.mode == MODE_SINGLE) || (q.mode == MODE_BURST);

  // ==================================================
  // next state
  always_comb begin
    logic [31:0] cur;
    logic [31:0] wv;
    cur = 32'h0000_0000;
    wv = 32'h0000_0000;
    n = q;
    // synchroniser for the comparator pin
    n.sync1 = trigComp;
    n.sync2 = q.sync1;
    n.lvlPrev = lvl;

    // write address and data are taken independently
    if (awvalid && q.awready) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (bready && q.bvalid) n.bvalid = 1'b0;

    // register write once both halves are held and no response is pending
    if (q.awHave && q.wHave && !q.bvalid) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = 2'h0;
      if (q.awAddr == `TRIG_OFF_CTRL) begin
        cur = {23'h0, q.intLevel, q.run, q.fixedClk, q.autoRate, q.limit,
               q.srcExt, q.slopeNeg, q.mode};
        wv = merge(cur, q.wData, q.wStrb);
        n.mode = mode_t'(wv[`TRIG_CTRL_MODE_LO +: 2]);
        n.slopeNeg = wv[`TRIG_CTRL_SLOPE];
        n.srcExt = wv[`TRIG_CTRL_SRCEXT];
        n.limit = wv[`TRIG_CTRL_LIMIT];
        n.autoRate = wv[`TRIG_CTRL_AUTO];
        n.fixedClk = wv[`TRIG_CTRL_FIXED];
        n.run = wv[`TRIG_CTRL_RUN];
        n.intLevel = wv[`TRIG_CTRL_INTLVL];
      end else if (q.awAddr == `TRIG_OFF_BURST) begin
        wv = merge({20'h0, q.burst}, q.wData, q.wStrb);
        if (wv[31:12] != 20'h0) n.burst = `TRIG_BURST_MAX;
        else if (wv[11:0] == 12'h000) n.burst = 12'h001;
        else n.burst = wv[11:0];
      end else if (q.awAddr == `TRIG_OFF_DELAY) begin
        n.delay = merge(q.delay, q.wData, q.wStrb);
      end else if (q.awAddr == `TRIG_OFF_DECADE) begin
        wv = merge({29'h0, q.decade}, q.wData, q.wStrb);
        if (q.limit && wv < 32'(`TRIG_DECADES)) n.decade = wv[2:0];
        else n.bresp = 2'h2;
      end else if (q.awAddr == `TRIG_OFF_FREQ) begin
        n.userRate = merge(q.userRate, q.wData, q.wStrb);
      end else if (q.awAddr == `TRIG_OFF_POINTS) begin
        wv = merge({16'h0, q.points}, q.wData, q.wStrb);
        n.points = (wv[15:0] == 16'h0000) ? 16'h0001 : wv[15:0];
        n.addr = 16'h0000;
      end else if (q.awAddr == `TRIG_OFF_STATUS) begin
        n.ignored = 16'h0000;
      end else begin
        n.bresp = 2'h2;
      end
    end
    n.awready = !n.awHave;
    n.wready = !n.wHave;

    // read channel, one outstanding read
    if (rready && q.rvalid) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (arvalid && q.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = 2'h0;
      if (araddr == `TRIG_OFF_CTRL)
        n.rdata = {23'h0, q.intLevel, q.run, q.fixedClk, q.autoRate, q.limit,
                   q.srcExt, q.slopeNeg, q.mode};
      else if (araddr == `TRIG_OFF_BURST) n.rdata = {20'h0, q.burst};
      else if (araddr == `TRIG_OFF_DELAY) n.rdata = q.delay;
      else if (araddr == `TRIG_OFF_DECADE) n.rdata = {29'h0, q.decade};
      else if (araddr == `TRIG_OFF_FREQ) n.rdata = q.rate;
      else if (araddr == `TRIG_OFF_POINTS) n.rdata = {16'h0, q.points};
      else if (araddr == `TRIG_OFF_STATUS)
        n.rdata = {q.ignored, 10'h0, q.repsLeft != 12'h000, gateOn, q.playing,
                   lvl, q.seq};
      else begin
        n.rdata = 32'h0000_0000;
        n.rresp = 2'h2;
      end
    end

    // edit engine proposals: rate only moves when variable and automatic
    if (editReq.valid) begin
      if (q.autoRate && !q.fixedClk) begin
        n.userRate = editReq.rate;
        n.points = (editReq.points == 16'h0000) ? 16'h0001 : editReq.points;
      end else begin
        n.points = (editReq.heldPoints == 16'h0000) ? 16'h0001 : editReq.heldPoints;
      end
      n.addr = 16'h0000;
    end
    n.rate = clampRate(n.userRate, n.limit, n.decade);

    // replay sequencer
    case (q.seq)
      SEQ_IDLE: begin
        n.addr = 16'h0000;
        if (q.run) begin
          if (q.mode == MODE_CONT) begin
            n.seq = SEQ_PLAY;
          end else if (q.mode == MODE_GATE) begin
            if (gateOn) n.seq = SEQ_PLAY;
          end else if (trigEvt) begin
            n.repsLeft = (q.mode == MODE_BURST) ? q.burst : 12'h001;
            n.delayCnt = q.delay;
            n.seq = (q.delay == 32'h0) ? SEQ_PLAY : SEQ_DELAY;
          end
        end
      end
      SEQ_DELAY: begin
        n.delayCnt = q.delayCnt - 32'h1;
        if (q.delayCnt == 32'h1) n.seq = SEQ_PLAY;
      end
      SEQ_PLAY: begin
        if (push) begin
          n.addr = lastSample ? 16'h0000 : q.addr + 16'h0001;
          if (lastSample && triggered) begin
            n.repsLeft = q.repsLeft - 12'h001;
            if (q.repsLeft == 12'h001) n.seq = SEQ_IDLE;
          end
        end
        if (q.mode == MODE_GATE && !gateOn) n.seq = SEQ_IDLE;
      end
      default: n.seq = SEQ_IDLE;
    endcase
    // a trigger during a running shot or burst is dropped and counted
    if (q.seq != SEQ_IDLE && triggered && q.run && trigEvt &&
        q.ignored != 16'hffff) begin
      n.ignored = q.ignored + 16'h0001;
    end
    // clearing run stops the sequencer at once
    if (!q.run) n.seq = SEQ_IDLE;
    if (!q.run) n.repsLeft = 12'h000;
    n.playing = (n.seq == SEQ_PLAY);

    if (rst) begin
      n = '0;
      n.awready = 1'b1;
      n.wready = 1'b1;
      n.arready = 1'b1;
      n.mode = MODE_CONT;
      n.seq = SEQ_IDLE;
      n.limit = `TRIG_RST_LIMIT;
      n.burst = `TRIG_RST_BURST;
      n.userRate = `TRIG_RST_RATE;
      n.rate = `TRIG_RST_RATE;
      n.points = `TRIG_RST_POINTS;
    end
  end

  always_ff @(posedge clk) begin
    q <= n;
  end

  // ==================================================
  // replay words leave through the fifo; a stalled sink stalls the sequencer
  replay_fifo #(
    .WIDTH ($bits(sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inData   (pushWord),
    .inValid  (push),
    .inReady  (fifoReady),
    .outData  (sampleOut),
    .outValid (sampleValid),
    .outReady (sampleReady)
  );

  assign awready    = q.awready;
  assign wready     = q.wready;
  assign bvalid     = q.bvalid;
  assign bresp      = q.bresp;
  assign arready    = q.arready;
  assign rvalid     = q.rvalid;
  assign rresp      = q.rresp;
  assign rdata      = q.rdata;
  assign filterSel  = q.decade;   // filter select is the decade index itself
  assign sampleRate = q.rate;
  assign playing    = q.playing;
endmodule : trigger_playback_clock_control
`default_nettype wire

// >>> trig_map.svh
// register offsets, field positions, reset values and rate limits of the trigger block
`ifndef TRIG_MAP_SVH
`define TRIG_MAP_SVH
// ==================================================
// register byte offsets
`define TRIG_OFF_CTRL    8'h00
`define TRIG_OFF_BURST   8'h04
`define TRIG_OFF_DELAY   8'h08
`define TRIG_OFF_DECADE  8'h0c
`define TRIG_OFF_FREQ    8'h10
`define TRIG_OFF_POINTS  8'h14
`define TRIG_OFF_STATUS  8'h18
// ==================================================
// control register field positions
`define TRIG_CTRL_MODE_LO  0
`define TRIG_CTRL_SLOPE    2
`define TRIG_CTRL_SRCEXT   3
`define TRIG_CTRL_LIMIT    4
`define TRIG_CTRL_AUTO     5
`define TRIG_CTRL_FIXED    6
`define TRIG_CTRL_RUN      7
`define TRIG_CTRL_INTLVL   8
// ==================================================
// reset values
`define TRIG_RST_BURST   12'h001
`define TRIG_RST_RATE    32'h17d7_8400
`define TRIG_RST_POINTS  16'h0001
`define TRIG_RST_LIMIT   1'b1
// ==================================================
// decade table and free-running limits, in hertz
`define TRIG_DECADES     3'h5
`define TRIG_DEC0_HI     32'd400000000
`define TRIG_DEC0_LO     32'd355000000
`define TRIG_DEC1_HI     32'd40000000
`define TRIG_DEC1_LO     32'd35500000
`define TRIG_DEC2_HI     32'd4000000
`define TRIG_DEC2_LO     32'd3550000
`define TRIG_DEC3_HI     32'd400000
`define TRIG_DEC3_LO     32'd355000
`define TRIG_DEC4_HI     32'd40000
`define TRIG_DEC4_LO     32'd35500
`define TRIG_FREE_LO     32'd6000
`define TRIG_FREE_HI     32'd400000000
`define TRIG_BURST_MAX   12'hfff
`endif

// >>> trig_pkg.sv
// types shared by the trigger sequencer and its ports
`default_nettype none
package trig_pkg;
  // ==================================================
  // modes and sequencer states
  typedef enum logic [1:0] {MODE_CONT, MODE_SINGLE, MODE_BURST, MODE_GATE} mode_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_PLAY} seq_t;
  // ==================================================
  // request from the edit engine and the replay stream word
  typedef struct packed {
    logic        valid;
    logic [31:0] rate;
    logic [15:0] points;
    logic [15:0] heldPoints;
  } edit_req_t;
  typedef struct packed {
    logic        last;
    logic [15:0] addr;
  } sample_t;
  // ==================================================
  // whole state of the top module
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        awHave;
    logic        wHave;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    mode_t       mode;
    logic        slopeNeg;
    logic        srcExt;
    logic        limit;
    logic        autoRate;
    logic        fixedClk;
    logic        run;
    logic        intLevel;
    logic [11:0] burst;
    logic [31:0] delay;
    logic [2:0]  decade;
    logic [31:0] userRate;
    logic [31:0] rate;
    logic [15:0] points;
    logic        sync1;
    logic        sync2;
    logic        lvlPrev;
    seq_t        seq;
    logic [31:0] delayCnt;
    logic [11:0] repsLeft;
    logic [15:0] addr;
    logic [15:0] ignored;
    logic        playing;
  } state_t;
endpackage : trig_pkg
`default_nettype wire

// >>> trig_checker.sv
// concurrent checks on the trigger sequencer ports
`timescale 1ns/1ps
`default_nettype none
module trig_checker
  import trig_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire sample_t     sampleOut,
  input wire logic        sampleValid,
  input wire logic        sampleReady,
  input wire logic [2:0]  filterSel,
  input wire logic [31:0] sampleRate,
  input wire logic        playing
);
  // ==========
  // handshake steps
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rdTaken;
    arvalid && arready;
  endsequence
  // ==========
  // properties
  property p_rstState;
    $fell(rst) |-> !playing && !sampleValid && filterSel == 3'h0 && awready && arready;
  endproperty
  property p_wrAnswer;
    s_wrTaken |-> ##[1:2] bvalid;
  endproperty
  property p_bHold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_rdAnswer;
    s_rdTaken |=> rvalid && !arready;
  endproperty
  property p_rHold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  property p_streamHold;
    sampleValid && !sampleReady |=> sampleValid && $stable(sampleOut);
  endproperty
  property p_filterRange;
    filterSel <= 3'h4;
  endproperty
  property p_rateRange;
    sampleRate >= 32'd6000 && sampleRate <= 32'd400000000;
  endproperty
  property p_respCode;
    bvalid |-> bresp == 2'b00 || bresp == 2'b10;
  endproperty
  // ==========
  // assertions
  a_rstState: assert property (p_rstState)
    else $error("outputs wrong after reset");
  a_wrAnswer: assert property (p_wrAnswer)
    else $error("write response late");
  a_bHold: assert property (p_bHold)
    else $error("write response dropped");
  a_rdAnswer: assert property (p_rdAnswer)
    else $error("read data late");
  a_rHold: assert property (p_rHold)
    else $error("read data dropped");
  a_streamHold: assert property (p_streamHold)
    else $error("stream word changed while stalled");
  a_filterRange: assert property (p_filterRange)
    else $error("filter select out of range");
  a_rateRange: assert property (p_rateRange)
    else $error("sample rate out of range");
  a_respCode: assert property (p_respCode)
    else $error("bad write response code");
endmodule : trig_checker
bind trigger_playback_clock_control trig_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .clk, .rst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rvalid, .rready, .sampleOut, .sampleValid,
  .sampleReady, .filterSel, .sampleRate, .playing
);
`default_nettype wire

// >>> far_side_model.sv
// far side: trigger comparator source and replay stream consumer
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input  wire logic clk,
  input  wire logic level,
  input  wire logic rnd,
  input  wire logic stall,
  output var  logic trigComp,
  output var  logic sampleReady
);
  // ==========
  // comparator crosses the threshold off the clock edge
  initial trigComp = 1'b0;
  always @(level) trigComp <= #3 level;
  // consumer takes words at random, or holds off while stalled
  initial sampleReady = 1'b0;
  always @(posedge clk) sampleReady <= rnd & ~stall;
endmodule : far_side_model
`default_nettype wire

// >>> tb.sv
// self-checking bench for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
`include "trig_map.svh"
module tb;
  import trig_pkg::*;
  // ==========
  // signals
  localparam logic [1:0] OK = 2'b00;
  localparam logic [1:0] ERR = 2'b10;
  localparam logic [31:0] LO[5] = '{`TRIG_DEC0_LO, `TRIG_DEC1_LO, `TRIG_DEC2_LO,
                                    `TRIG_DEC3_LO, `TRIG_DEC4_LO};
  localparam logic [31:0] HI[5] = '{`TRIG_DEC0_HI, `TRIG_DEC1_HI, `TRIG_DEC2_HI,
                                    `TRIG_DEC3_HI, `TRIG_DEC4_HI};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  edit_req_t   editReq = '0;
  logic        level = 1'b0;
  logic        stall = 1'b0;
  logic        rnd = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic [31:0] seed = 32'h6d2930a7;
  logic        awready, wready, bvalid, arready, rvalid, trigComp, sampleReady;
  logic        sampleValid, playing;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, sampleRate;
  logic [2:0]  filterSel;
  sample_t     sampleOut;
  logic [33:0] expQ[$];
  int          n_errors = 0;
  int          checks_done = 0;
  int          nWords = 0;
  int          nLast = 0;
  int          pts = 0;
  // ==========
  // design and far side
  trigger_playback_clock_control #(.FIFO_DEPTH(8)) dut (
    .clk(clk), .rst(rst), .trigComp(trigComp), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .editReq(editReq), .sampleOut(sampleOut), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .filterSel(filterSel), .sampleRate(sampleRate),
    .playing(playing)
  );
  far_side_model far (.clk(clk), .level(level), .rnd(rnd), .stall(stall),
    .trigComp(trigComp), .sampleReady(sampleReady));
  // clock and random source
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  always @(posedge clk) begin
    seed <= lfsr(seed);
    rnd <= seed[0];
  end
  // ==========
  // tasks
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    // late bready exercises the held response
    repeat (2) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    // late rready exercises the held read data
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd
  task automatic waitPlay(input logic v, input int lim);
    int n;
    n = 0;
    while (playing !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check({33'h0, playing}, {33'h0, v});
  endtask : waitPlay
  task automatic drain;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((playing || sampleValid) && n < 300);
  endtask : drain
  task automatic edit(input logic [31:0] r, input logic [15:0] p);
    editReq <= '{1'b1, r, p, p};
    @(posedge clk);
    editReq.valid <= 1'b0;
    @(posedge clk);
  endtask : edit
  task automatic finish_test;
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // ==========
  // score answers and count stream words
  always @(posedge clk) begin
    if (bvalid && bready) check({bresp, 32'h0}, expQ.pop_front());
    if (rvalid && rready) check({rresp, rdata}, expQ.pop_front());
    if (sampleValid && sampleReady && pts > 0)
      check({17'h0, sampleOut}, {17'h0, nWords % pts == pts - 1, 16'(nWords % pts)});
    if (sampleValid && sampleReady) nWords++;
    if (sampleValid && sampleReady && sampleOut.last) nLast++;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`TRIG_OFF_CTRL, 32'h10, OK);
    rd(`TRIG_OFF_POINTS, 32'h1, OK);
    rd(8'h1c, 32'h0, ERR);
    wr(8'h1c, 32'h5, ERR);
    wr(`TRIG_OFF_BURST, 32'h0, OK);
    rd(`TRIG_OFF_BURST, 32'h1, OK);
    wr(`TRIG_OFF_BURST, 32'h1000, OK);
    rd(`TRIG_OFF_BURST, 32'hfff, OK);
    wstrb <= 4'h2;
    wr(`TRIG_OFF_BURST, 32'h300, OK);
    wstrb <= 4'hf;
    rd(`TRIG_OFF_BURST, 32'h3ff, OK);
    for (int d = 0; d < 5; d++) begin
      wr(`TRIG_OFF_DECADE, 32'(d), OK);
      wr(`TRIG_OFF_FREQ, 32'h1, OK);
      rd(`TRIG_OFF_FREQ, LO[d], OK);
      check(34'(filterSel), 34'(d));
      wr(`TRIG_OFF_FREQ, 32'hffffffff, OK);
      rd(`TRIG_OFF_FREQ, HI[d], OK);
    end
    wr(`TRIG_OFF_DECADE, 32'h5, ERR);
    wr(`TRIG_OFF_CTRL, 32'h0, OK);
    wr(`TRIG_OFF_DECADE, 32'h1, ERR);
    rd(`TRIG_OFF_DECADE, 32'h4, OK);
    wr(`TRIG_OFF_FREQ, 32'h1, OK);
    rd(`TRIG_OFF_FREQ, 32'd6000, OK);
    r = 32'd6000 + (seed % 32'd399994001);
    wr(`TRIG_OFF_FREQ, r, OK);
    rd(`TRIG_OFF_FREQ, r, OK);
    // edit requests against auto and fixed clock
    wr(`TRIG_OFF_CTRL, 32'h20, OK);
    edit(32'd7000000, 16'h9);
    rd(`TRIG_OFF_FREQ, 32'd7000000, OK);
    wr(`TRIG_OFF_CTRL, 32'h60, OK);
    edit(32'd8000000, 16'h7);
    rd(`TRIG_OFF_FREQ, 32'd7000000, OK);
    rd(`TRIG_OFF_POINTS, 32'h7, OK);
    wr(`TRIG_OFF_FREQ, 32'd5000000, OK);
    rd(`TRIG_OFF_FREQ, 32'd5000000, OK);
    wr(`TRIG_OFF_CTRL, 32'h0, OK);
    edit(32'd9000000, 16'h4);
    rd(`TRIG_OFF_FREQ, 32'd5000000, OK);
    rd(`TRIG_OFF_POINTS, 32'h4, OK);
    // continuous replay ignores the comparator input
    wr(`TRIG_OFF_CTRL, 32'h80, OK);
    waitPlay(1'b1, 20);
    repeat (30) begin
      @(posedge clk);
      level <= ~level;
      waitPlay(1'b1, 0);
    end
    wr(`TRIG_OFF_CTRL, 32'h0, OK);
    drain();
    // single shot, second trigger while stalled
    level <= 1'b0;
    nWords = 0;
    nLast = 0;
    pts = 20;
    wr(`TRIG_OFF_POINTS, 32'd20, OK);
    wr(`TRIG_OFF_CTRL, 32'h89, OK);
    stall <= 1'b1;
    level <= 1'b1;
    waitPlay(1'b1, 20);
    level <= 1'b0;
    repeat (4) @(posedge clk);
    level <= 1'b1;
    repeat (10) @(posedge clk);
    stall <= 1'b0;
    drain();
    check(34'(nWords), 34'd20);
    check(34'(nLast), 34'd1);
    rd(`TRIG_OFF_STATUS, 32'h0001_0014, OK);
    // burst on a falling edge
    nWords = 0;
    nLast = 0;
    pts = 4;
    level <= 1'b0;
    wr(`TRIG_OFF_BURST, 32'h3, OK);
    wr(`TRIG_OFF_POINTS, 32'h4, OK);
    wr(`TRIG_OFF_CTRL, 32'h8e, OK);
    level <= 1'b1;
    repeat (10) @(posedge clk);
    waitPlay(1'b0, 0);
    level <= 1'b0;
    waitPlay(1'b1, 20);
    drain();
    check(34'(nWords), 34'd12);
    check(34'(nLast), 34'd3);
    // delay from trigger to output
    nWords = 0;
    pts = 2;
    wr(`TRIG_OFF_DELAY, 32'd12, OK);
    wr(`TRIG_OFF_POINTS, 32'h2, OK);
    wr(`TRIG_OFF_CTRL, 32'h89, OK);
    level <= 1'b1;
    repeat (12) @(posedge clk);
    waitPlay(1'b0, 0);
    waitPlay(1'b1, 10);
    drain();
    check(34'(nWords), 34'd2);
    // gate under negative slope
    wr(`TRIG_OFF_DELAY, 32'h0, OK);
    wr(`TRIG_OFF_CTRL, 32'h8f, OK);
    repeat (8) @(posedge clk);
    waitPlay(1'b0, 0);
    level <= 1'b0;
    waitPlay(1'b1, 10);
    repeat (20) @(posedge clk);
    waitPlay(1'b1, 0);
    level <= 1'b1;
    waitPlay(1'b0, 10);
    drain();
    // internal source follows its level bit only
    nWords = 0;
    pts = 3;
    wr(`TRIG_OFF_POINTS, 32'h3, OK);
    wr(`TRIG_OFF_CTRL, 32'h81, OK);
    level <= 1'b0;
    repeat (4) @(posedge clk);
    level <= 1'b1;
    repeat (10) @(posedge clk);
    waitPlay(1'b0, 0);
    wr(`TRIG_OFF_CTRL, 32'h181, OK);
    drain();
    check(34'(nWords), 34'd3);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : tb
`default_nettype wire
